// *** logic/cct_core.sv ***
// Two-instance capture/compare timer with byte register port
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module cct_core (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  output logic            irq,
  input  wire logic [2:0] chan_pin_in,
  output logic      [2:0] chan_pin_out,
  output logic      [2:0] chan_pin_oe_n,
  output logic      [2:0] chan_pullup_ok
);
  cct_pkg::cct_state_t s_q;
  cct_pkg::cct_state_t s_d;

  // Prescaler tick: divide by 2^ps, ps 0..6 (seven rates); 7 behaves as 6
  function automatic logic tick_of(input cct_pkg::cct_tmr_t t);
    logic [6:0] m;
    m = 7'h00;
    case (t.ps)
      3'h0: m = 7'h00;
      3'h1: m = 7'h01;
      3'h2: m = 7'h03;
      3'h3: m = 7'h07;
      3'h4: m = 7'h0f;
      3'h5: m = 7'h1f;
      default: m = 7'h3f;
    endcase
    return !t.halt && ((t.pre & m) == m);
  endfunction

  // Counter step: halt holds, limit wraps to zero and raises flag
  function automatic cct_pkg::cct_tmr_t step(input cct_pkg::cct_tmr_t t);
    cct_pkg::cct_tmr_t n;
    n = t;
    if (!t.halt) begin
      n.pre = t.pre + 7'h01;
      if (tick_of(t)) begin
        n.pre = cct_pkg::CCT_PS_RESET;
        if (t.cnt == t.wrap) begin
          n.cnt  = 16'h0000;
          n.flag = 1'b1;
        end else begin
          n.cnt = t.cnt + 16'h0001;
        end
      end
    end
    return n;
  endfunction

  // Channel step; hit is taken against the shared counter
  function automatic cct_pkg::cct_chan_t chan_step(
      input cct_pkg::cct_chan_t c, input cct_pkg::cct_tmr_t t,
      input logic pin_in, input logic msb_ok);
    cct_pkg::cct_chan_t n;
    logic cap;
    logic rise;
    logic fall;
    logic tk;
    n = c;
    cap  = 1'b0;
    tk   = tick_of(t);
    rise = pin_in && !c.pin_last;
    fall = !pin_in && c.pin_last;
    n.pin_last = pin_in;
    if (!c.ctl[cct_pkg::CCT_CH_MSA] &&
        !(msb_ok && c.ctl[cct_pkg::CCT_CH_MSB])) begin
      unique case ({c.ctl[cct_pkg::CCT_CH_ELSB], c.ctl[cct_pkg::CCT_CH_ELSA]})
        2'b01:   cap = rise;
        2'b10:   cap = fall;
        2'b11:   cap = rise || fall;
        default: cap = 1'b0;
      endcase
      if (cap) begin
        n.val = t.cnt;
        n.ctl[cct_pkg::CCT_CH_FLAG] = 1'b1;
      end
    end else if (tk) begin
      if (c.ctl[cct_pkg::CCT_CH_TOV] && t.cnt == t.wrap) begin
        n.pin = !c.pin;
      end
      if (t.cnt == c.val) begin
        n.ctl[cct_pkg::CCT_CH_FLAG] = 1'b1;
        unique case ({c.ctl[cct_pkg::CCT_CH_ELSB], c.ctl[cct_pkg::CCT_CH_ELSA]})
          2'b01:   n.pin = !c.pin;
          2'b10:   n.pin = 1'b0;
          2'b11:   n.pin = 1'b1;
          default: ; // No pin action, so a wrap toggle survives
        endcase
      end
      if (c.ctl[cct_pkg::CCT_CH_MAX]) begin
        n.pin = 1'b1;
      end
    end
    return n;
  endfunction

  function automatic cct_pkg::cct_tmr_t tmr_wr(
      input cct_pkg::cct_tmr_t t, input logic [7:0] d);
    cct_pkg::cct_tmr_t n;
    n = t;
    n.ie   = d[cct_pkg::CCT_SC_IE];
    n.halt = d[cct_pkg::CCT_SC_HALT];
    n.ps   = d[2:0];
    if (!d[cct_pkg::CCT_SC_FLAG]) begin
      n.flag = 1'b0;
    end
    if (d[cct_pkg::CCT_SC_RST]) begin
      n.cnt = 16'h0000;
      n.pre = cct_pkg::CCT_PS_RESET;
    end
    return n;
  endfunction

  // Flag kept if hardware set it this cycle: set wins over clear
  function automatic logic [7:0] ch_wr(
      input logic [7:0] old, input logic [7:0] nxt, input logic [7:0] d,
      input logic msb_ok);
    logic [7:0] r;
    r = d;
    r[cct_pkg::CCT_CH_FLAG] = old[cct_pkg::CCT_CH_FLAG] &
                              d[cct_pkg::CCT_CH_FLAG];
    if (nxt[cct_pkg::CCT_CH_FLAG] && !old[cct_pkg::CCT_CH_FLAG]) begin
      r[cct_pkg::CCT_CH_FLAG] = 1'b1;
    end
    if (!msb_ok) begin
      r[cct_pkg::CCT_CH_MSB] = 1'b0;
    end
    return r;
  endfunction

  function automatic logic [7:0] sc_rd(input cct_pkg::cct_tmr_t t);
    return {t.flag, t.ie, t.halt, 2'b00, t.ps};
  endfunction

  always_comb begin
    logic f1;
    logic f2;
    s_d = s_q;
    f1 = 1'b0;
    f2 = 1'b0;
    s_d.t1  = step(s_q.t1);
    s_d.t2  = step(s_q.t2);
    s_d.c10 = chan_step(s_q.c10, s_q.t1, chan_pin_in[0], 1'b1);
    s_d.c11 = chan_step(s_q.c11, s_q.t1, chan_pin_in[1], 1'b0);
    s_d.c20 = chan_step(s_q.c20, s_q.t2, chan_pin_in[2], 1'b1);
    f1 = s_d.t1.flag && !s_q.t1.flag;
    f2 = s_d.t2.flag && !s_q.t2.flag;
    if (wr) begin
      unique case (addr)
        cct_pkg::CCT_T1_SC: begin
          s_d.t1 = tmr_wr(s_d.t1, wdata);
          if (f1) begin
            s_d.t1.flag = 1'b1;
          end
        end
        cct_pkg::CCT_T2_SC: begin
          s_d.t2 = tmr_wr(s_d.t2, wdata);
          if (f2) begin
            s_d.t2.flag = 1'b1;
          end
        end
        cct_pkg::CCT_T1_MODH: s_d.t1.wrap[15:8] = wdata;
        cct_pkg::CCT_T1_MODL: s_d.t1.wrap[7:0]  = wdata;
        cct_pkg::CCT_T2_MODH: s_d.t2.wrap[15:8] = wdata;
        cct_pkg::CCT_T2_MODL: s_d.t2.wrap[7:0]  = wdata;
        cct_pkg::CCT_T1_C0SC:
          s_d.c10.ctl = ch_wr(s_q.c10.ctl, s_d.c10.ctl, wdata, 1'b1);
        cct_pkg::CCT_T1_C1SC:
          s_d.c11.ctl = ch_wr(s_q.c11.ctl, s_d.c11.ctl, wdata, 1'b0);
        cct_pkg::CCT_T2_C0SC:
          s_d.c20.ctl = ch_wr(s_q.c20.ctl, s_d.c20.ctl, wdata, 1'b1);
        cct_pkg::CCT_T1_C0H: s_d.c10.val[15:8] = wdata;
        cct_pkg::CCT_T1_C0L: s_d.c10.val[7:0]  = wdata;
        cct_pkg::CCT_T1_C1H: s_d.c11.val[15:8] = wdata;
        cct_pkg::CCT_T1_C1L: s_d.c11.val[7:0]  = wdata;
        cct_pkg::CCT_T2_C0H: s_d.c20.val[15:8] = wdata;
        cct_pkg::CCT_T2_C0L: s_d.c20.val[7:0]  = wdata;
        default: ;
      endcase
    end
    s_d.rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        cct_pkg::CCT_T1_SC:   s_d.rdata = sc_rd(s_q.t1);
        cct_pkg::CCT_T1_CNTH: s_d.rdata = s_q.t1.cnt[15:8];
        cct_pkg::CCT_T1_CNTL: s_d.rdata = s_q.t1.cnt[7:0];
        cct_pkg::CCT_T1_MODH: s_d.rdata = s_q.t1.wrap[15:8];
        cct_pkg::CCT_T1_MODL: s_d.rdata = s_q.t1.wrap[7:0];
        cct_pkg::CCT_T1_C0SC: s_d.rdata = s_q.c10.ctl;
        cct_pkg::CCT_T1_C0H:  s_d.rdata = s_q.c10.val[15:8];
        cct_pkg::CCT_T1_C0L:  s_d.rdata = s_q.c10.val[7:0];
        cct_pkg::CCT_T1_C1SC: s_d.rdata = s_q.c11.ctl;
        cct_pkg::CCT_T1_C1H:  s_d.rdata = s_q.c11.val[15:8];
        cct_pkg::CCT_T1_C1L:  s_d.rdata = s_q.c11.val[7:0];
        cct_pkg::CCT_T2_SC:   s_d.rdata = sc_rd(s_q.t2);
        cct_pkg::CCT_T2_CNTH: s_d.rdata = s_q.t2.cnt[15:8];
        cct_pkg::CCT_T2_CNTL: s_d.rdata = s_q.t2.cnt[7:0];
        cct_pkg::CCT_T2_MODH: s_d.rdata = s_q.t2.wrap[15:8];
        cct_pkg::CCT_T2_MODL: s_d.rdata = s_q.t2.wrap[7:0];
        cct_pkg::CCT_T2_C0SC: s_d.rdata = s_q.c20.ctl;
        cct_pkg::CCT_T2_C0H:  s_d.rdata = s_q.c20.val[15:8];
        cct_pkg::CCT_T2_C0L:  s_d.rdata = s_q.c20.val[7:0];
        default:              s_d.rdata = 8'h00; // Reserved and unmapped
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
      s_q.t1.halt <= 1'b1;
      s_q.t2.halt <= 1'b1;
      s_q.t1.wrap <= cct_pkg::CCT_MOD_RESET;
      s_q.t2.wrap <= cct_pkg::CCT_MOD_RESET;
      s_q.c10.ctl <= cct_pkg::CCT_CH_RESET;
      s_q.c11.ctl <= cct_pkg::CCT_CH_RESET;
      s_q.c20.ctl <= cct_pkg::CCT_CH_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  function automatic logic is_out(input logic [7:0] c, input logic msb_ok);
    return c[cct_pkg::CCT_CH_MSA] || (msb_ok && c[cct_pkg::CCT_CH_MSB]);
  endfunction

  assign rdata = s_q.rdata;
  assign chan_pin_out = {s_q.c20.pin, s_q.c11.pin, s_q.c10.pin};
  assign chan_pin_oe_n = {!is_out(s_q.c20.ctl, 1'b1),
                          !is_out(s_q.c11.ctl, 1'b0),
                          !is_out(s_q.c10.ctl, 1'b1)};
  // Pullup only legal on capture channels; port control gates it outside
  assign chan_pullup_ok = chan_pin_oe_n;
  assign irq = (s_q.t1.flag && s_q.t1.ie) || (s_q.t2.flag && s_q.t2.ie) ||
               (s_q.c10.ctl[7] && s_q.c10.ctl[6]) ||
               (s_q.c11.ctl[7] && s_q.c11.ctl[6]) ||
               (s_q.c20.ctl[7] && s_q.c20.ctl[6]);

  AST_RESET_HALT: assert property (@(posedge mclk)
    $past(rst) && !rst |-> s_q.t1.halt && !s_q.t1.flag && s_q.t1.ps == 3'h0)
    else $error("halt not set after reset");
  AST_WRAP_RESET: assert property (@(posedge mclk)
    $past(rst) && !rst |-> s_q.t1.wrap == cct_pkg::CCT_MOD_RESET &&
    s_q.t2.wrap == cct_pkg::CCT_MOD_RESET)
    else $error("wrap limit not all ones after reset");
  AST_HALT_HOLD: assert property (@(posedge mclk) disable iff (rst)
    s_q.t1.halt && !(wr && addr == 8'h20) |=> $stable(s_q.t1.cnt))
    else $error("counter moved while halted");
  AST_WRAP_ZERO: assert property (@(posedge mclk) disable iff (rst)
    !wr && !s_q.t1.halt && s_q.t1.ps == 3'h0 &&
    s_q.t1.cnt == s_q.t1.wrap |=> s_q.t1.cnt == 16'h0000 && s_q.t1.flag)
    else $error("no wrap to zero with flag");
  AST_COUNT_UP: assert property (@(posedge mclk) disable iff (rst)
    !wr && !s_q.t1.halt && s_q.t1.ps == 3'h0 &&
    s_q.t1.cnt != s_q.t1.wrap |=> s_q.t1.cnt == $past(s_q.t1.cnt) + 16'h1)
    else $error("counter did not step by one");
  AST_RESET_BIT: assert property (@(posedge mclk) disable iff (rst)
    wr && addr == 8'h20 && wdata[4] |=> s_q.t1.cnt == 16'h0000)
    else $error("reset bit did not clear counter");
  AST_READ_CNT: assert property (@(posedge mclk) disable iff (rst)
    rd && addr == 8'h22 |=> rdata == $past(s_q.t1.cnt[7:0]))
    else $error("counter low read mismatch");
  AST_CH1_BIT5: assert property (@(posedge mclk) disable iff (rst)
    s_q.c11.ctl[5] == 1'b0)
    else $error("channel 1 bit 5 not zero");
  AST_SC_BIT3: assert property (@(posedge mclk) disable iff (rst)
    rd && (addr == 8'h20 || addr == 8'h2b) |=> rdata[4:3] == 2'b00)
    else $error("timer control bits 4..3 not zero");
  AST_CAPTURE: assert property (@(posedge mclk) disable iff (rst)
    !s_q.c10.ctl[5] && !s_q.c10.ctl[4] && s_q.c10.ctl[3:2] == 2'b01 &&
    chan_pin_in[0] && !s_q.c10.pin_last &&
    !(wr && (addr == 8'h26 || addr == 8'h27))
    |=> s_q.c10.val == $past(s_q.t1.cnt))
    else $error("capture did not latch counter");
  AST_CAPTURE_FLAG: assert property (@(posedge mclk)
    disable iff (rst)
    !s_q.c10.ctl[5] && !s_q.c10.ctl[4] && s_q.c10.ctl[3:2] == 2'b01 &&
    chan_pin_in[0] && !s_q.c10.pin_last |=> s_q.c10.ctl[7])
    else $error("capture did not raise channel flag");

  // Register writes land one cycle after the strobe
  AST_WRAP_WRITE: assert property (@(posedge mclk)
    disable iff (rst)
    wr && addr == cct_pkg::CCT_T1_MODL |=> s_q.t1.wrap[7:0] == $past(wdata))
    else $error("wrap limit low byte not written");
  AST_CH0_WRITE: assert property (@(posedge mclk)
    disable iff (rst)
    wr && addr == cct_pkg::CCT_T1_C0SC |=>
    s_q.c10.ctl[6:0] == $past(wdata[6:0]))
    else $error("channel 0 control bits not written");
  AST_T2_VALUE: assert property (@(posedge mclk)
    disable iff (rst)
    wr && addr == cct_pkg::CCT_T2_C0H |=> s_q.c20.val[15:8] == $past(wdata))
    else $error("second timer channel value not written");
  AST_RSVD_READ: assert property (@(posedge mclk)
    disable iff (rst)
    rd && addr == cct_pkg::CCT_T2_RSVD |=> rdata == 8'h00)
    else $error("reserved location read not zero");
  AST_T2_CNT_RD: assert property (@(posedge mclk)
    disable iff (rst)
    rd && addr == cct_pkg::CCT_T2_CNTH |=> rdata == $past(s_q.t2.cnt[15:8]))
    else $error("second counter high read mismatch");
  AST_T2_HOLD: assert property (@(posedge mclk)
    disable iff (rst)
    s_q.t2.halt && !(wr && addr == cct_pkg::CCT_T2_SC) |=>
    $stable(s_q.t2.cnt))
    else $error("second counter moved while halted");

  // Flag only drops on a write of zero; a write of one leaves it alone
  AST_FLAG_KEEP: assert property (@(posedge mclk)
    disable iff (rst)
    s_q.t1.flag &&
    !(wr && addr == cct_pkg::CCT_T1_SC && !wdata[cct_pkg::CCT_SC_FLAG])
    |=> s_q.t1.flag)
    else $error("overflow flag dropped without a clearing write");
  AST_FLAG_CLR: assert property (@(posedge mclk)
    disable iff (rst)
    wr && addr == cct_pkg::CCT_T1_SC && !wdata[cct_pkg::CCT_SC_FLAG] &&
    s_q.t1.halt |=> !s_q.t1.flag)
    else $error("overflow flag not cleared by write of zero");
  AST_IRQ_RAISE: assert property (@(posedge mclk)
    disable iff (rst)
    s_q.t1.flag && wr && addr == cct_pkg::CCT_T1_SC &&
    wdata[cct_pkg::CCT_SC_FLAG] && wdata[cct_pkg::CCT_SC_IE] |=> irq)
    else $error("enabled overflow flag raised no interrupt");

  // With prescale 4 the counter only moves on every fourth cycle
  AST_PRESCALE: assert property (@(posedge mclk)
    disable iff (rst)
    !wr && s_q.t1.ps == 3'h2 && s_q.t1.pre[1:0] != 2'b11 |=>
    $stable(s_q.t1.cnt))
    else $error("counter moved between prescaled ticks");

  // Pin drive and pullup permission follow the channel mode
  AST_MODE_OE: assert property (@(posedge mclk)
    disable iff (rst)
    chan_pin_oe_n[1] == !s_q.c11.ctl[cct_pkg::CCT_CH_MSA] &&
    chan_pin_oe_n[2] == !(s_q.c20.ctl[cct_pkg::CCT_CH_MSA] ||
                          s_q.c20.ctl[cct_pkg::CCT_CH_MSB]))
    else $error("pin drive does not follow channel mode");
  AST_NO_PULLUP: assert property (@(posedge mclk)
    disable iff (rst)
    s_q.c10.ctl[cct_pkg::CCT_CH_MSA] |-> !chan_pullup_ok[0])
    else $error("pullup allowed on a compare channel");

  // Compare channels of both timers, counter ticking every cycle
  AST_CMP_SET: assert property (@(posedge mclk)
    disable iff (rst)
    s_q.c20.ctl[cct_pkg::CCT_CH_MSA] && s_q.c20.ctl[3:2] == 2'b11 &&
    !s_q.t2.halt && s_q.t2.ps == 3'h0 && s_q.t2.cnt == s_q.c20.val
    |=> chan_pin_out[2])
    else $error("compare match did not set pin");
  AST_CMP_CLR: assert property (@(posedge mclk)
    disable iff (rst)
    s_q.c20.ctl[cct_pkg::CCT_CH_MSA] && s_q.c20.ctl[3:2] == 2'b10 &&
    !s_q.c20.ctl[cct_pkg::CCT_CH_MAX] &&
    !s_q.t2.halt && s_q.t2.ps == 3'h0 && s_q.t2.cnt == s_q.c20.val
    |=> !chan_pin_out[2])
    else $error("compare match did not clear pin");
  AST_WRAP_TOGGLE: assert property (@(posedge mclk)
    disable iff (rst)
    s_q.c11.ctl[cct_pkg::CCT_CH_MSA] && s_q.c11.ctl[3:0] == 4'h2 &&
    !s_q.t1.halt && s_q.t1.ps == 3'h0 &&
    s_q.t1.cnt == s_q.t1.wrap |=> chan_pin_out[1] != $past(chan_pin_out[1]))
    else $error("pin did not toggle at wrap limit");

  COV_WRAP: cover property (@(posedge mclk) s_q.t1.flag && s_q.t1.cnt == 16'h0);
  COV_CAPTURE: cover property (@(posedge mclk) s_q.c10.ctl[7]);
  COV_COMPARE: cover property (@(posedge mclk) $changed(chan_pin_out[2]));
  COV_IRQ: cover property (@(posedge mclk) irq);
  COV_TOGGLE: cover property (@(posedge mclk) $changed(chan_pin_out[1]));
endmodule

// *** logic/cct_pkg.sv ***
// Constants and types shared by the capture/compare timer core
package cct_pkg;
  localparam logic [7:0] CCT_T1_SC    = 8'h20;
  localparam logic [7:0] CCT_T1_CNTH  = 8'h21;
  localparam logic [7:0] CCT_T1_CNTL  = 8'h22;
  localparam logic [7:0] CCT_T1_MODH  = 8'h23;
  localparam logic [7:0] CCT_T1_MODL  = 8'h24;
  localparam logic [7:0] CCT_T1_C0SC  = 8'h25;
  localparam logic [7:0] CCT_T1_C0H   = 8'h26;
  localparam logic [7:0] CCT_T1_C0L   = 8'h27;
  localparam logic [7:0] CCT_T1_C1SC  = 8'h28;
  localparam logic [7:0] CCT_T1_C1H   = 8'h29;
  localparam logic [7:0] CCT_T1_C1L   = 8'h2a;
  localparam logic [7:0] CCT_T2_SC    = 8'h2b;
  localparam logic [7:0] CCT_T2_CNTH  = 8'h2c;
  localparam logic [7:0] CCT_T2_CNTL  = 8'h2d;
  localparam logic [7:0] CCT_T2_MODH  = 8'h2e;
  localparam logic [7:0] CCT_T2_MODL  = 8'h2f;
  localparam logic [7:0] CCT_T2_C0SC  = 8'h30;
  localparam logic [7:0] CCT_T2_C0H   = 8'h31;
  localparam logic [7:0] CCT_T2_C0L   = 8'h32;
  localparam logic [7:0] CCT_T2_RSVD  = 8'h33;
  // Timer control bit positions
  localparam int CCT_SC_FLAG  = 7;
  localparam int CCT_SC_IE    = 6;
  localparam int CCT_SC_HALT  = 5;
  localparam int CCT_SC_RST   = 4;
  // Channel control bit positions
  localparam int CCT_CH_FLAG  = 7;
  localparam int CCT_CH_IE    = 6;
  localparam int CCT_CH_MSB   = 5;
  localparam int CCT_CH_MSA   = 4;
  localparam int CCT_CH_ELSB  = 3;
  localparam int CCT_CH_ELSA  = 2;
  localparam int CCT_CH_TOV   = 1;
  localparam int CCT_CH_MAX   = 0;
  localparam logic [7:0]  CCT_SC_RESET  = 8'h20;
  localparam logic [7:0]  CCT_CH_RESET  = 8'h00;
  localparam logic [15:0] CCT_MOD_RESET = 16'hffff;
  localparam logic [6:0]  CCT_PS_RESET  = 7'h00;

  typedef struct packed {
    logic        flag;
    logic        ie;
    logic        halt;
    logic [2:0]  ps;
    logic [6:0]  pre;
    logic [15:0] cnt;
    logic [15:0] wrap;
  } cct_tmr_t;

  typedef struct packed {
    logic [7:0]  ctl;
    logic [15:0] val;
    logic        pin;
    logic        pin_last;
  } cct_chan_t;

  typedef struct packed {
    cct_tmr_t     t1;
    cct_tmr_t     t2;
    cct_chan_t    c10;
    cct_chan_t    c11;
    cct_chan_t    c20;
    logic [7:0]   rdata;
  } cct_state_t;
endpackage

// *** tb/cct_core_bench.sv ***
// Register-level bench for the capture/compare timer core
`timescale 1ns/1ps
module cct_core_bench;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic       irq;
  logic [2:0] pin_in;
  logic [2:0] pin_out;
  logic [2:0] oe_n;
  logic [2:0] pull_ok;
  logic [2:0] drv = 3'h0;
  logic [2:0] drv_en = 3'h7;
  logic [7:0] v;
  logic [7:0] a;
  logic [7:0] b;
  int         miscompares = 0;
  int         n_checks = 0;
  int         cyc = 0;
  int         n;
  logic [7:0] ra [13] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h28,
                          8'h2b, 8'h2c, 8'h2e, 8'h2f, 8'h30, 8'h33};
  logic [7:0] re [13] = '{8'h20, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00,
                          8'h20, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};
  logic [7:0] cm [3] = '{8'h1c, 8'h18, 8'h14};
  logic       cp [3] = '{1'b1, 1'b0, 1'b1};

  always #12.5 mclk = ~mclk;

  cct_core u_cct_core (
    .mclk           (mclk),
    .rst            (rst),
    .addr           (addr),
    .wdata          (wdata),
    .wr             (wr),
    .rd             (rd),
    .rdata          (rdata),
    .irq            (irq),
    .chan_pin_in    (pin_in),
    .chan_pin_out   (pin_out),
    .chan_pin_oe_n  (oe_n),
    .chan_pullup_ok (pull_ok)
  );

  cct_pin_model u_cct_pin_model (
    .mclk    (mclk),
    .drv     (drv),
    .drv_en  (drv_en),
    .pin_out (pin_out),
    .oe_n    (oe_n),
    .pull_ok (pull_ok),
    .pin_in  (pin_in)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] ad, input logic [7:0] d);
    @(posedge mclk);
    addr  <= ad;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] ad, output logic [7:0] d);
    @(posedge mclk);
    addr <= ad;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(ad, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask

  // Same cycle count with or without reads, so counts must agree
  task automatic span(input logic [2:0] ps, input bit reads);
    logic [7:0] d;
    wr_reg(8'h20, {5'h00, ps});
    for (int i = 0; i < 16; i++) begin
      if (reads)
        rd_reg(8'h22, d);
      else
        repeat (2) @(posedge mclk);
    end
    wr_reg(8'h20, {5'h04, ps});
  endtask

  task automatic stop_test;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      stop_test;
    end
  end

  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 13; i++) rd_chk(ra[i], re[i]);
    chk({13'h0, oe_n}, 16'h0007);
    chk({13'h0, pull_ok}, 16'h0007);
    $display("test reset values done");

    wr_reg(8'h20, 8'h3f);
    rd_chk(8'h20, 8'h27);
    wr_reg(8'h28, 8'hff);
    rd_chk(8'h28, 8'h5f);
    wr_reg(8'h25, 8'h7f);
    rd_chk(8'h25, 8'h7f);
    wr_reg(8'h23, 8'ha5);
    rd_chk(8'h23, 8'ha5);
    wr_reg(8'h21, 8'h55);
    rd_chk(8'h21, 8'h00);
    wr_reg(8'h33, 8'hff);
    rd_chk(8'h33, 8'h00);
    wr_reg(8'h28, 8'h00);
    wr_reg(8'h25, 8'h00);
    wr_reg(8'h23, 8'hff);
    $display("test field access done");

    wr_reg(8'h20, 8'h30);
    span(3'h0, 1'b0);
    rd_reg(8'h22, a);
    rd_chk(8'h22, a);
    wr_reg(8'h20, 8'h30);
    span(3'h0, 1'b1);
    rd_reg(8'h22, b);
    chk({8'h0, b}, {8'h0, a});
    chk({15'h0, a > 8'h10}, 16'h1);
    wr_reg(8'h20, 8'h32);
    span(3'h2, 1'b0);
    rd_reg(8'h22, b);
    chk({15'h0, b + 8'h1 >= a / 4 && b <= a / 4 + 1}, 16'h1);
    $display("test counting done");

    wr_reg(8'h23, 8'h00);
    wr_reg(8'h24, 8'h05);
    wr_reg(8'h20, 8'h30);
    wr_reg(8'h20, 8'h00);
    repeat (10) @(posedge mclk);
    wr_reg(8'h20, 8'h80);
    rd_chk(8'h20, 8'h80);
    chk({15'h0, irq}, 16'h0);
    wr_reg(8'h20, 8'hc0);
    #1 chk({15'h0, irq}, 16'h1);
    wr_reg(8'h20, 8'he0);
    rd_reg(8'h22, v);
    chk({15'h0, v <= 8'h05}, 16'h1);
    wr_reg(8'h20, 8'h60);
    rd_chk(8'h20, 8'h60);
    chk({15'h0, irq}, 16'h0);
    $display("test overflow done");

    wr_reg(8'h23, 8'hff);
    wr_reg(8'h24, 8'hff);
    wr_reg(8'h20, 8'h30);
    wr_reg(8'h25, 8'h44);
    wr_reg(8'h20, 8'h00);
    repeat (5) @(posedge mclk);
    drv[0] <= 1'b1;
    repeat (5) @(posedge mclk);
    wr_reg(8'h20, 8'h20);
    rd_chk(8'h25, 8'hc4);
    chk({15'h0, irq}, 16'h1);
    rd_reg(8'h27, a);
    rd_reg(8'h22, b);
    chk({15'h0, b - a >= 8'h2 && b - a <= 8'h14}, 16'h1);
    chk({15'h0, pull_ok[0]}, 16'h1);
    wr_reg(8'h25, 8'h00);
    $display("test capture done");

    wr_reg(8'h31, 8'h00);
    wr_reg(8'h32, 8'h03);
    for (int i = 0; i < 3; i++) begin
      wr_reg(8'h2b, 8'h30);
      wr_reg(8'h30, cm[i]);
      wr_reg(8'h2b, 8'h00);
      repeat (12) @(posedge mclk);
      wr_reg(8'h2b, 8'h20);
      #1 chk({15'h0, pin_out[2]}, {15'h0, cp[i]});
      chk({15'h0, oe_n[2]}, 16'h0);
      rd_chk(8'h30, cm[i] | 8'h80);
      wr_reg(8'h30, cm[i]);
    end
    $display("test compare done");

    wr_reg(8'h23, 8'h00);
    wr_reg(8'h24, 8'h07);
    wr_reg(8'h28, 8'h12);
    wr_reg(8'h25, 8'h11);
    wr_reg(8'h20, 8'h30);
    wr_reg(8'h20, 8'h00);
    n = 0;
    for (int i = 0; i < 64; i++) begin
      v[0] = pin_out[1];
      @(posedge mclk);
      #1 if (pin_out[1] !== v[0]) n++;
    end
    wr_reg(8'h20, 8'h20);
    chk({15'h0, n >= 7 && n <= 9}, 16'h1);
    chk({15'h0, pin_out[0]}, 16'h1);
    $display("test toggle on wrap done");
    stop_test;
  end
endmodule

// *** tb/cct_pin_model.sv ***
// Far-side pin model: external event sources and compare output loads
`timescale 1ns/1ps
module cct_pin_model (
  input  wire logic       mclk,
  input  wire logic [2:0] drv,
  input  wire logic [2:0] drv_en,
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] oe_n,
  input  wire logic [2:0] pull_ok,
  output logic      [2:0] pin_in
);
  logic wobble = 1'b0;
  // Undriven pin without pullup must not look stable
  always @(posedge mclk) wobble <= ~wobble;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!oe_n[i])
        pin_in[i] = pin_out[i];
      else if (drv_en[i])
        pin_in[i] = drv[i];
      else
        pin_in[i] = pull_ok[i] ? 1'b1 : wobble;
    end
  end
endmodule
